// >>> rtl/pse_mode_map.vh
// constants for the pse mode and address control block
// assumes a byte-wide command/data front end that has already decoded the bus
`ifndef PSE_MODE_MAP_VH
`define PSE_MODE_MAP_VH

// ****************************************
// command codes
// ****************************************
`define CMD_PIN_STATUS  8'h11
`define CMD_OP_MODE     8'h12
`define CMD_DISC_EN     8'h14
`define CMD_PWR_ON      8'h19
`define CMD_RESET       8'h1A
`define CMD_ALLOC       8'h29

// ****************************************
// fields and values
// ****************************************
`define MODE_OFF        2'h0
`define MODE_MANUAL     2'h1
`define MODE_SEMI       2'h2
`define MODE_AUTO       2'h3
`define STRAP_DIS       2'h0
`define STRAP_15W       2'h1
`define STRAP_30W       2'h2
`define PRE_ALLOC_15W   8'h00
`define PRE_ALLOC_30W   8'h33
`define ALLOC_30W       4'h3
`define CLASS_LIM_15W   4'h3
`define CLASS_LIM_30W   4'h4
`define GLOBAL_RST_BIT  7
`define ADDR_FIXED      2'h1
`define ADDR_BCAST      7'h7F
`define BYTE_ZERO       8'h00
`define CHAN_CNT        4

`endif

// >>> rtl/pse_addr_match.v
// i2c target address compare for one four-channel group
// assumes the address byte is already shifted in by the bus front end
`timescale 1ns/10ps
`default_nettype none
`include "pse_mode_map.vh"

module pse_addr_match (
    // received address
    input  wire [6:0] rx_addr,
    // address straps
    input  wire [3:0] strap,
    input  wire       group,
    // result
    output wire       hit
);

    wire [6:0] own_addr;

    assign own_addr = {`ADDR_FIXED, strap, group};
    assign hit      = (rx_addr == own_addr) || (rx_addr == `ADDR_BCAST);

endmodule // pse_addr_match
`default_nettype wire

// >>> rtl/pse_chan_seq.v
// per-channel discovery and power sequencer
// assumes detection and classification engines answer with done pulses
`timescale 1ns/10ps
`default_nettype none
`include "pse_mode_map.vh"

module pse_chan_seq (
    // clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // control
    input  wire [1:0] mode,
    input  wire       det_en,
    input  wire       cls_en,
    input  wire       pwr_cmd,
    input  wire       kill,
    // measurement results
    input  wire       det_done,
    input  wire       det_ok,
    input  wire       cls_done,
    input  wire       pwr_fault,
    // outputs
    output reg        detect_run,
    output reg        class_run,
    output reg        power_en,
    output reg        det_taken,
    output reg        cls_taken
);

    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_DET  = 4'h2;
    localparam [3:0] S_CLS  = 4'h4;
    localparam [3:0] S_PWR  = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg       next_det_taken;
    reg       next_cls_taken;
    wire      manual;
    wire      autom;

    assign manual = (mode == `MODE_MANUAL);
    assign autom  = (mode == `MODE_AUTO);

    always @* begin
        next_state = state;
        next_det_taken = 1'b0;
        next_cls_taken = 1'b0;
        case (state)
            S_IDLE: begin
                if (det_en) begin
                    next_state = S_DET;
                    next_det_taken = manual;
                end else if (manual && cls_en) begin
                    next_state = S_CLS;
                    next_cls_taken = 1'b1;
                end
            end
            S_DET: begin
                if (det_done) begin
                    if (manual && cls_en) begin
                        next_state = S_CLS;
                        next_cls_taken = 1'b1;
                    end else if (!manual && det_ok && cls_en) begin
                        next_state = S_CLS;
                    end else begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_CLS: begin
                if (cls_done) begin
                    // only auto powers a found load on its own
                    next_state = autom ? S_PWR : S_IDLE;
                end
            end
            S_PWR: begin
                if (pwr_fault) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // power-on wins over a running measurement
        if (pwr_cmd) begin
            next_state = S_PWR;
        end
        if ((mode == `MODE_OFF) || kill) begin
            next_state = S_IDLE;
            next_det_taken = 1'b0;
            next_cls_taken = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            state      <= S_IDLE;
            detect_run <= 1'b0;
            class_run  <= 1'b0;
            power_en   <= 1'b0;
            det_taken  <= 1'b0;
            cls_taken  <= 1'b0;
        end else begin
            state      <= next_state;
            detect_run <= (next_state == S_DET);
            class_run  <= (next_state == S_CLS);
            power_en   <= (next_state == S_PWR);
            det_taken  <= next_det_taken;
            cls_taken  <= next_cls_taken;
        end
    end

endmodule // pse_chan_seq
`default_nettype wire

// >>> rtl/pse_mode_and_address_control.v
// mode control, autonomous preset and address reporting, four channels
// assumes an i2c front end that hands over address, command and data bytes
//
// Overview of operation
// - pin status 0x11 is read-only; bits 6:3 show the four address straps
// - bit 2 is the group bit and address lsb; 0 channels 1-4, 1 channels 5-8
// - configuration b forces the group bit to zero
// - autonomous ports cycle discovery without commands and power valid loads
// - one autonomous strap presets mode, enables and allocation for all ports
// - a class above the autonomous limit is powered demoted to that limit
// - the i2c side keeps full read and write access in autonomous mode
// - the strap is sampled only at power-up; mode and enable presets also reload in rom autonomous
// - rom autonomous: resets and off commands stop ports, then discovery resumes
// - sram autonomous: after such events ports stay off until the host acts
// - operating mode 0x12 resets to zero, two bits per channel
// - mode code: 00 off, 01 manual, 10 semiauto, 11 auto
// - off mode: unpowered, no detection or classification at all
// - going off clears the channel's event flags
// - going off clears class, detect, power status and enable bits
// - going off sets the channel's policing register to all ones
// - going off clears the channel's measurements
// - going off clears assigned class, autoclass, port flag and foldback
// - the off clearing touches only the channel switched off
// - manual: one cycle per enable set, power-on command powers at once
// - semiauto: detect only, detect plus class, or idle by the enables
`timescale 1ns/10ps
`default_nettype none
`include "pse_mode_map.vh"

module pse_mode_and_address_control (
    // clock and power-up reset
    input  wire        clk_sys,
    input  wire        srst,
    // device reset pin, already synchronous
    input  wire        reset_req_n,
    // i2c command front end
    input  wire [6:0]  i2c_addr,
    input  wire        i2c_wr,
    input  wire        i2c_rd,
    input  wire [7:0]  i2c_cmd,
    input  wire [7:0]  i2c_wdata,
    output reg         i2c_ack,
    output reg  [7:0]  i2c_rdata,
    // straps
    input  wire [3:0]  addr_strap_bits,
    input  wire        group_sel,
    input  wire        config_b,
    input  wire [1:0]  auto_strap,
    input  wire        sram_programmed,
    // per-channel measurement results
    input  wire [3:0]  det_done,
    input  wire [3:0]  det_ok,
    input  wire [3:0]  cls_done,
    input  wire [3:0]  pwr_fault,
    input  wire [15:0] req_class,
    // per-channel control out
    output wire [3:0]  detect_run,
    output wire [3:0]  class_run,
    output wire [3:0]  channel_on_status,
    output reg  [15:0] grant_class,
    output reg  [3:0]  off_clear,
    output reg  [7:0]  power_alloc,
    output reg         autonomous
);

    // ****************************************
    // straps and address
    // ****************************************
    reg  [3:0] strap_q;
    reg        group_q;
    reg  [1:0] auto_cfg;
    reg        por_pending;
    wire       hit;
    wire       rom_auto;

    always @(posedge clk_sys) begin
        if (srst) begin
            strap_q <= 4'h0;
            group_q <= 1'b0;
        end else begin
            strap_q <= addr_strap_bits;
            group_q <= config_b ? 1'b0 : group_sel;
        end
    end

    pse_addr_match u_addr (
        .rx_addr (i2c_addr),
        .strap   (strap_q),
        .group   (group_q),
        .hit     (hit)
    );

    // ****************************************
    // access decode
    // ****************************************
    // decode never looks at the autonomous state
    wire wr_ok;
    wire rd_ok;
    wire wr_mode;
    wire wr_en;
    wire wr_pwr;
    wire wr_rst;
    wire wr_alloc;
    wire glob_rst;
    wire dev_rst;

    assign wr_ok    = i2c_wr && hit;
    assign rd_ok    = i2c_rd && hit;
    assign wr_mode  = wr_ok && (i2c_cmd == `CMD_OP_MODE);
    assign wr_en    = wr_ok && (i2c_cmd == `CMD_DISC_EN);
    assign wr_pwr   = wr_ok && (i2c_cmd == `CMD_PWR_ON);
    assign wr_rst   = wr_ok && (i2c_cmd == `CMD_RESET);
    assign wr_alloc = wr_ok && (i2c_cmd == `CMD_ALLOC);
    assign glob_rst = wr_rst && i2c_wdata[`GLOBAL_RST_BIT];
    assign dev_rst  = glob_rst || !reset_req_n;
    assign rom_auto = (auto_cfg != `STRAP_DIS) && !sram_programmed;

    // ****************************************
    // power-up strap sampling and allocation
    // ****************************************
    // the strap is caught one edge after power-up release, never on later resets
    always @(posedge clk_sys) begin
        if (srst) begin
            por_pending <= 1'b1;
            auto_cfg    <= `STRAP_DIS;
            autonomous  <= 1'b0;
        end else if (por_pending) begin
            por_pending <= 1'b0;
            auto_cfg    <= auto_strap;
            autonomous  <= (auto_strap != `STRAP_DIS);
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            power_alloc <= `BYTE_ZERO;
        end else if (por_pending) begin
            if (auto_strap == `STRAP_30W) begin
                power_alloc <= `PRE_ALLOC_30W;
            end else begin
                power_alloc <= `PRE_ALLOC_15W;
            end
        end else if (dev_rst && !rom_auto) begin
            power_alloc <= `BYTE_ZERO;
        end else if (wr_alloc) begin
            power_alloc <= i2c_wdata;
        end
    end

    // ****************************************
    // per-channel mode, enables and sequencer
    // ****************************************
    wire [7:0] mode_vec;
    wire [3:0] det_en_vec;
    wire [3:0] cls_en_vec;

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_CNT; ch = ch + 1) begin : g_chan
            reg  [1:0] mode;
            reg  [1:0] next_mode;
            reg        det_en;
            reg        cls_en;
            reg        next_det_en;
            reg        next_cls_en;
            reg        resume;
            wire       port_rst;
            wire       kill;
            wire       going_off;
            wire       det_taken;
            wire       cls_taken;
            wire       preset;
            wire [3:0] limit;
            wire [3:0] req;

            assign port_rst = wr_rst && i2c_wdata[ch];
            assign kill     = dev_rst || port_rst;
            // rom autonomous reloads its preset, sram autonomous waits for the host
            assign preset   = rom_auto && (kill || resume);

            always @* begin
                next_mode   = mode;
                next_det_en = det_en;
                next_cls_en = cls_en;
                if (preset) begin
                    next_mode   = `MODE_AUTO;
                    next_det_en = 1'b1;
                    next_cls_en = 1'b1;
                end else if (kill) begin
                    next_mode   = `MODE_OFF;
                    next_det_en = 1'b0;
                    next_cls_en = 1'b0;
                end else begin
                    if (wr_mode) begin
                        next_mode = i2c_wdata[2*ch+1:2*ch];
                    end
                    if (wr_en) begin
                        next_det_en = i2c_wdata[ch];
                        next_cls_en = i2c_wdata[ch+4];
                    end else begin
                        // manual mode runs one cycle per enable
                        if (det_taken) begin
                            next_det_en = 1'b0;
                        end
                        if (cls_taken) begin
                            next_cls_en = 1'b0;
                        end
                    end
                    if ((mode != `MODE_OFF) && (next_mode == `MODE_OFF)) begin
                        next_det_en = 1'b0;
                        next_cls_en = 1'b0;
                    end
                end
            end

            assign going_off = ((mode != `MODE_OFF) && (next_mode == `MODE_OFF))
                               || kill;

            always @(posedge clk_sys) begin
                if (srst) begin
                    mode      <= `MODE_OFF;
                    det_en    <= 1'b0;
                    cls_en    <= 1'b0;
                    resume    <= 1'b0;
                    off_clear[ch] <= 1'b0;
                end else if (por_pending) begin
                    if (auto_strap != `STRAP_DIS) begin
                        mode   <= `MODE_AUTO;
                        det_en <= 1'b1;
                        cls_en <= 1'b1;
                    end
                    resume    <= 1'b0;
                    off_clear[ch] <= 1'b0;
                end else begin
                    mode      <= next_mode;
                    det_en    <= next_det_en;
                    cls_en    <= next_cls_en;
                    // a mode-off in rom autonomous comes back on the next edge
                    resume    <= rom_auto && !kill && going_off;
                    // one pulse clears this channel's flags, status, class,
                    // measurements, sets policing to all ones; others untouched
                    off_clear[ch] <= going_off;
                end
            end

            pse_chan_seq u_seq (
                .clk_sys    (clk_sys),
                .srst       (srst),
                .mode       (mode),
                .det_en     (det_en),
                .cls_en     (cls_en),
                .pwr_cmd    (wr_pwr && i2c_wdata[ch] && (mode != `MODE_OFF)),
                .kill       (kill || going_off),
                .det_done   (det_done[ch]),
                .det_ok     (det_ok[ch]),
                .cls_done   (cls_done[ch]),
                .pwr_fault  (pwr_fault[ch]),
                .detect_run (detect_run[ch]),
                .class_run  (class_run[ch]),
                .power_en   (channel_on_status[ch]),
                .det_taken  (det_taken),
                .cls_taken  (cls_taken)
            );

            // channels 1-2 take the low allocation nibble, 3-4 the high one
            assign limit = (power_alloc[4*(ch/2)+3:4*(ch/2)] == `ALLOC_30W) ?
                           `CLASS_LIM_30W : `CLASS_LIM_15W;
            assign req   = req_class[4*ch+3:4*ch];

            always @(posedge clk_sys) begin
                if (srst) begin
                    grant_class[4*ch+3:4*ch] <= 4'h0;
                end else if (going_off) begin
                    grant_class[4*ch+3:4*ch] <= 4'h0;
                end else if (autonomous && (req > limit)) begin
                    grant_class[4*ch+3:4*ch] <= limit;
                end else begin
                    grant_class[4*ch+3:4*ch] <= req;
                end
            end

            assign mode_vec[2*ch+1:2*ch] = mode;
            assign det_en_vec[ch]        = det_en;
            assign cls_en_vec[ch]        = cls_en;
        end
    endgenerate

    // ****************************************
    // read path and acknowledge
    // ****************************************
    // unmapped commands read zero so a stray read never returns stale data
    reg [7:0] next_rdata;

    always @* begin
        case (i2c_cmd)
            `CMD_PIN_STATUS: next_rdata = {1'b0, strap_q, group_q, 2'b00};
            `CMD_OP_MODE:    next_rdata = mode_vec;
            `CMD_DISC_EN:    next_rdata = {cls_en_vec, det_en_vec};
            `CMD_ALLOC:      next_rdata = power_alloc;
            default:         next_rdata = `BYTE_ZERO;
        endcase
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            i2c_ack   <= 1'b0;
            i2c_rdata <= `BYTE_ZERO;
        end else begin
            i2c_ack <= wr_ok || rd_ok;
            if (rd_ok) begin
                i2c_rdata <= next_rdata;
            end
        end
    end

endmodule // pse_mode_and_address_control
`default_nettype wire

// >>> tb/pse_mode_asserts.sv
// port checker for the mode and address control block
// assumes one clock and a bind onto the top module
`timescale 1ns/10ps
`default_nettype none
module pse_mode_asserts (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        reset_req_n,
    // command front end
    input wire logic [6:0]  i2c_addr,
    input wire logic        i2c_wr,
    input wire logic        i2c_rd,
    input wire logic [7:0]  i2c_cmd,
    input wire logic [7:0]  i2c_wdata,
    input wire logic        i2c_ack,
    input wire logic [7:0]  i2c_rdata,
    // straps
    input wire logic [3:0]  addr_strap_bits,
    input wire logic        group_sel,
    input wire logic        config_b,
    input wire logic [1:0]  auto_strap,
    // channel state
    input wire logic [3:0]  detect_run,
    input wire logic [3:0]  class_run,
    input wire logic [3:0]  channel_on_status,
    input wire logic [15:0] grant_class,
    input wire logic [3:0]  off_clear,
    input wire logic [7:0]  power_alloc,
    input wire logic        autonomous
);
    // ****************************************
    // helpers
    // ****************************************
    logic       grp;
    logic       req;
    logic [3:0] nz;
    logic       cap_ok;
    assign grp = group_sel & ~config_b;
    assign req = (i2c_wr | i2c_rd) &
                 ((i2c_addr == {2'h1, addr_strap_bits, grp}) || (i2c_addr == 7'h7F));
    always_comb begin
        cap_ok = 1'b1;
        for (int n = 0; n < 4; n++) begin
            nz[n] = |i2c_wdata[2*n +: 2];
            if (grant_class[4*n +: 4] > ((power_alloc[4*(n/2) +: 4] == 4'h3) ? 4'h4 : 4'h3))
                cap_ok = 1'b0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ****************************************
    // assertions
    // ****************************************
    a_ack_on_hit: assert property (
        req |=> i2c_ack) else $error("ack missing after addressed request");
    a_ack_needs_hit: assert property (
        i2c_ack |-> $past(req)) else $error("ack without addressed request");
    a_pin_status: assert property (
        req && i2c_rd && i2c_cmd == 8'h11 |=>
        i2c_rdata == {1'b0, $past(addr_strap_bits), $past(grp), 2'h0})
        else $error("pin status read wrong");
    a_rdata_hold: assert property (
        !$past(req && i2c_rd) && !$past(srst) |-> $stable(i2c_rdata))
        else $error("read data moved without read");
    a_off_stops: assert property (
        req && i2c_wr && i2c_cmd == 8'h12 |=>
        ({channel_on_status, detect_run, class_run} & {3{~$past(nz)}}) == 12'h000)
        else $error("off channel still active");
    a_off_own_only: assert property (
        req && i2c_wr && i2c_cmd == 8'h12 |=> (off_clear & $past(nz)) == 4'h0)
        else $error("clear pulse on channel kept running");
    a_off_clears: assert property (
        ((channel_on_status | detect_run | class_run) & off_clear) == 4'h0)
        else $error("cleared channel still active");
    a_pin_kill: assert property (
        !reset_req_n |=> channel_on_status == 4'h0) else $error("reset pin left power on");
    a_global_kill: assert property (
        req && i2c_wr && i2c_cmd == 8'h1A && i2c_wdata[7] |=> channel_on_status == 4'h0)
        else $error("global reset left power on");
    a_preset_load: assert property (
        $fell(srst) |=> autonomous == ($past(auto_strap) != 2'h0) &&
        power_alloc == (($past(auto_strap) == 2'h2) ? 8'h33 : 8'h00))
        else $error("power-up preset wrong");
    a_strap_once: assert property (
        $rose(autonomous) |-> $past(srst, 2)) else $error("strap taken after power-up");
    a_demote_cap: assert property (
        autonomous && $past(autonomous) && $stable(power_alloc) |-> cap_ok)
        else $error("granted class above limit");
endmodule // pse_mode_asserts

bind pse_mode_and_address_control pse_mode_asserts u_asserts (.*);
`default_nettype wire

// >>> tb/pse_engine_model.sv
// detection and classification engine stand-in, four channels
// assumes registered run flags
`timescale 1ns/10ps
`default_nettype none
module pse_engine_model (
    // clock
    input  wire logic       clk_sys,
    // run requests
    input  wire logic [3:0] detect_run,
    input  wire logic [3:0] class_run,
    // bench controls
    input  wire logic [3:0] load_ok,
    input  wire logic [3:0] fault_in,
    // results
    output var  logic [3:0] det_done,
    output wire logic [3:0] det_ok,
    output var  logic [3:0] cls_done,
    output wire logic [3:0] pwr_fault
);
    logic [3:0] cnt [0:3] = '{4'h0, 4'h0, 4'h0, 4'h0};
    initial begin
        det_done = 4'h0;
        cls_done = 4'h0;
    end
    assign det_ok    = load_ok;
    assign pwr_fault = fault_in;
    // channel n answers after 2+3n cycles: prompt and slow ports side by side
    always @(posedge clk_sys) begin
        for (int n = 0; n < 4; n++) begin
            det_done[n] <= detect_run[n] && cnt[n] == 4'(2 + 3*n);
            cls_done[n] <= class_run[n] && cnt[n] == 4'(2 + 3*n);
            if ((detect_run[n] | class_run[n]) && cnt[n] != 4'(2 + 3*n))
                cnt[n] <= cnt[n] + 4'h1;
            else
                cnt[n] <= 4'h0;
        end
    end
endmodule // pse_engine_model
`default_nettype wire

// >>> tb/pse_mode_and_address_control_bench.sv
// self-checking bench for the mode and address control block
// assumes the engine model; bus requests are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module pse_mode_and_address_control_bench;
    logic        clk_sys, srst, reset_req_n, i2c_wr, i2c_rd, i2c_ack, group_sel;
    logic        config_b, sram_programmed, autonomous;
    logic [6:0]  i2c_addr;
    logic [7:0]  i2c_cmd, i2c_wdata, i2c_rdata, power_alloc, m;
    logic [3:0]  addr_strap_bits, det_done, det_ok, cls_done, pwr_fault, load_ok, fault_in;
    logic [3:0]  detect_run, class_run, channel_on_status, off_clear;
    logic [1:0]  auto_strap, seen;
    logic [15:0] req_class, grant_class;
    logic [8:0]  expq[$];
    logic [8:0]  note;
    int          n_mismatch = 0;
    int          check_count = 0;

    pse_mode_and_address_control dut (.*);
    pse_engine_model u_eng (.*);

    // ****************************************
    // checking
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp);
        check_count++;
        if (seen_v !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen_v);
        end
    endtask

    task automatic test_done;
        check("pending acks", 16'(expq.size()), 16'h0);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // sel 0 broadcast, 1 own, 2 silent neighbour
    task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] wd,
                        input logic [7:0] exp, input logic [1:0] sel);
        @(posedge clk_sys);
        #1;
        i2c_addr = (sel == 2'h0) ? 7'h7F :
                   {2'h1, addr_strap_bits, group_sel & ~config_b} ^ {6'h0, sel[1]};
        i2c_rd = rd;
        i2c_wr = !rd;
        i2c_cmd = cmd;
        i2c_wdata = wd;
        if (sel != 2'h2)
            expq.push_back({rd, exp});
        @(posedge clk_sys);
        #1;
        i2c_rd = 1'b0;
        i2c_wr = 1'b0;
    endtask

    task automatic wait_on(input logic [3:0] want);
        for (int i = 0; i < 300 && channel_on_status !== want; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check("power status", channel_on_status, want);
    endtask

    always @(posedge clk_sys) begin
        if (i2c_ack === 1'b1) begin
            if (expq.size() == 0)
                check("stray ack", 16'h1, 16'h0);
            else begin
                note = expq.pop_front();
                if (note[8])
                    check("read data", i2c_rdata, note[7:0]);
            end
        end
    end

    // ****************************************
    // clock, watchdog and scenarios
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial begin
        void'($urandom(25));
        {srst, reset_req_n, i2c_wr, i2c_rd, i2c_addr, i2c_cmd, i2c_wdata} = {2'h3, 25'h0};
        {addr_strap_bits, group_sel, config_b, auto_strap, sram_programmed} = 9'h15C;
        {load_ok, fault_in, req_class} = {8'hF0, 16'h8888};
        repeat (10) @(posedge clk_sys);
        #1 srst = 1'b0;
        xfer(1, 8'h12, 8'h00, 8'hFF, 2'h1);
        xfer(1, 8'h14, 8'h00, 8'hFF, 2'h0);
        xfer(1, 8'h29, 8'h00, 8'h33, 2'h1);
        xfer(1, 8'h55, 8'h00, 8'h00, 2'h0);
        wait_on(4'hF);
        check("grant", grant_class, 16'h4444);
        for (int i = 0; i < 9; i++) begin
            addr_strap_bits = 4'($urandom);
            group_sel = 1'($urandom);
            config_b = i[0];
            xfer(0, 8'h11, 8'hFF, 8'h00, 2'h1);
            xfer(1, 8'h11, 8'h00, {1'b0, addr_strap_bits, group_sel & ~config_b, 2'h0},
                 2'(i % 3));
        end
        sram_programmed = 1'b1;
        xfer(0, 8'h12, 8'hFC, 8'h00, 2'h1);
        check("clear pulse", off_clear, 4'h1);
        check("others kept", channel_on_status, 4'hE);
        for (int c = 1; c < 5; c++) begin
            m = {4{2'(c % 4)}};
            xfer(0, 8'h12, m, 8'h00, 2'h0);
            xfer(1, 8'h12, 8'h00, m, 2'h1);
        end
        xfer(0, 8'h14, 8'hFF, 8'h00, 2'h1);
        xfer(0, 8'h19, 8'h0F, 8'h00, 2'h1);
        repeat (30) @(posedge clk_sys);
        #1 check("off idle", {detect_run, channel_on_status}, 8'h00);
        xfer(0, 8'h12, 8'h01, 8'h00, 2'h1);
        xfer(0, 8'h19, 8'h01, 8'h00, 2'h1);
        wait_on(4'h1);
        xfer(0, 8'h12, 8'h09, 8'h00, 2'h1);
        xfer(0, 8'h14, 8'h02, 8'h00, 2'h1);
        seen = 2'h0;
        repeat (40) begin
            @(posedge clk_sys);
            #1 seen = seen | {detect_run[1], class_run[1]};
        end
        check("semiauto detect only", seen, 2'h2);
        auto_strap = 2'h0;
        reset_req_n = 1'b0;
        @(posedge clk_sys);
        #1 reset_req_n = 1'b1;
        xfer(1, 8'h12, 8'h00, 8'h00, 2'h1);
        check("no resample", {autonomous, power_alloc}, 9'h100);
        repeat (40) @(posedge clk_sys);
        #1 check("stay off", channel_on_status, 4'h0);
        sram_programmed = 1'b0;
        xfer(0, 8'h1A, 8'h80, 8'h00, 2'h0);
        xfer(1, 8'h12, 8'h00, 8'hFF, 2'h1);
        wait_on(4'hF);
        xfer(0, 8'h1A, 8'h01, 8'h00, 2'h1);
        wait_on(4'hF);
        xfer(0, 8'h12, 8'h00, 8'h00, 2'h1);
        xfer(1, 8'h12, 8'h00, 8'hFF, 2'h1);
        xfer(0, 8'h29, 8'h03, 8'h00, 2'h1);
        xfer(1, 8'h29, 8'h00, 8'h03, 2'h0);
        repeat (2) @(posedge clk_sys);
        #1 check("demoted grant", grant_class, 16'h3344);
        srst = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 srst = 1'b0;
        xfer(1, 8'h12, 8'h00, 8'h00, 2'h1);
        xfer(1, 8'h29, 8'h00, 8'h00, 2'h0);
        check("strap disabled", autonomous, 1'b0);
        repeat (3) @(posedge clk_sys);
        test_done();
    end
endmodule // pse_mode_and_address_control_bench
`default_nettype wire
